/* File: verilog/afc_pkg.sv */
package afc_pkg;

   // clock and strobe timing
   localparam int unsigned CLK_MHZ = 10;
   localparam int unsigned STROBE_LOW_NS = 200;
   localparam int unsigned RECOVER_NS = 400;
   localparam int unsigned CLEAR_LOW_NS = 200;

   // least times: round up to whole cycles, never below one
   function automatic int unsigned afc_ns_to_cyc(input int unsigned ns);
      int unsigned cyc;
      cyc = (ns * CLK_MHZ + 999) / 1000;
      if (cyc == 0) begin
         cyc = 1;
      end
      return cyc;
   endfunction

   localparam int unsigned STROBE_LOW_CYC = afc_ns_to_cyc(STROBE_LOW_NS);
   localparam int unsigned RECOVER_CYC = afc_ns_to_cyc(RECOVER_NS);
   localparam int unsigned CLEAR_LOW_CYC = afc_ns_to_cyc(CLEAR_LOW_NS);
   localparam int unsigned TMR_W = 8;

   // register map, byte addresses
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_RDATA = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // field positions
   localparam int unsigned CTRL_DEPTH_BIT = 0;
   localparam int unsigned CMD_CLEAR_BIT = 0;
   localparam int unsigned CMD_REPLAY_BIT = 1;
   localparam int unsigned CMD_READ_BIT = 2;
   localparam int unsigned ST_BUSY_BIT = 0;
   localparam int unsigned ST_EMPTY_BIT = 1;
   localparam int unsigned ST_FULL_BIT = 2;
   localparam int unsigned ST_HALF_BIT = 3;
   localparam int unsigned ST_RVALID_BIT = 4;
   localparam int unsigned ST_ERR_BIT = 5;

   // reset values
   localparam logic CTRL_DEPTH_RST = 1'b0;

   typedef enum logic [2:0] {
      AFC_IDLE = 3'b000,
      AFC_WAIT = 3'b001,
      AFC_LOW = 3'b011,
      AFC_REC = 3'b010,
      AFC_CLEAR = 3'b110,
      AFC_REPLAY = 3'b111
   } afc_state_t;

   typedef enum logic [1:0] {
      AFC_OP_NONE = 2'b00,
      AFC_OP_WR = 2'b01,
      AFC_OP_RD = 2'b10
   } afc_op_t;

endpackage

/* File: verilog/afc_sync.sv */
`timescale 1ns/100ps
module afc_sync #(
   parameter int unsigned W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } afc_sync_t;

   afc_sync_t r;
   afc_sync_t next_r;

   always_comb begin
      next_r = r;
      next_r.s1 = din;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // a bit counts once the second and third stages agree
      for (int i = 0; i < W; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.q[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '1;
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.q;
endmodule

/* File: verilog/afc_timer.sv */
`timescale 1ns/100ps
module afc_timer
   import afc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [TMR_W-1:0] len,
   output logic expired
);
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
   } afc_timer_t;

   afc_timer_t r;
   afc_timer_t next_r;

   always_comb begin
      next_r = r;
      if (load) begin
         next_r.cnt = len;
      end else if (r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign expired = (r.cnt == '0) && !load;
endmodule

/* File: verilog/afc_ctrl.sv */
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
// Function
// (RULE1) device stands alone while its cascade input is low
// (RULE2) depth chain: head select low on device zero only, high elsewhere
// (RULE3) each cascade output feeds the next device's cascade input
// (RULE4) composite empty and full are the OR of all active-low flags
// (RULE5) depth chain offers no replay and no half indication
// (RULE6) width expansion: common controls, flags from any one device
// (RULE7) read flow-through drives the word until the read strobe rises
// (RULE8) read flow-through: empty deasserts briefly then reasserts
// (RULE9) write flow-through: full drops on read, new word stored on strobe rise
// (RULE10) writer toggles the write strobe only while full is deasserted
// (RULE11) clear in single or width mode zeroes pointers, empty low, full high
// (RULE12) replay low returns read pointer to zero, write pointer kept
// (RULE13) each pointer advances only while its flag is high
// (RULE14) clear in depth mode zeroes pointers on every device
// (RULE15) writer watches full, reader watches empty
// (RULE16) depth chain: cascade pulse at last memory location
// (RULE17) half indication low past half fill, released on a read rise
// (RULE18) full goes low when write pointer is one behind read pointer
// (RULE19) empty goes low when read pointer equals write pointer
// (RULE20) in depth chain only the token holder accepts accesses
module afc_ctrl
   import afc_pkg::*;
#(
   parameter int unsigned NDEV = 1,
   parameter int unsigned DW = 9
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic wr_n,
   output logic rd_n,
   output logic [DW-1:0] din,
   input wire logic [DW-1:0] dout,
   output logic clear_n,
   output logic [NDEV-1:0] chain_head_or_replay_n,
   input wire logic [NDEV-1:0] empty_ind_n,
   input wire logic [NDEV-1:0] full_ind_n,
   input wire logic half_ind_n
);
   localparam int unsigned SW = 2 * NDEV + 1 + DW;

   if (NDEV < 1 || NDEV > 32 || DW < 1 || DW > 32) begin : g_bad_size
      $error("afc_ctrl: NDEV and DW must lie in 1..32");
   end
   if (STROBE_LOW_CYC >= (1 << TMR_W) || RECOVER_CYC >= (1 << TMR_W)
       || CLEAR_LOW_CYC >= (1 << TMR_W)) begin : g_bad_timer
      $error("afc_ctrl: timing counts exceed timer width");
   end

   typedef struct packed {
      afc_state_t st;
      afc_op_t op;
      logic wr_n;
      logic rd_n;
      logic clr_n;
      logic rt_n;
      logic [NDEV-1:0] head_n;
      logic [DW-1:0] din;
      logic [DW-1:0] rdata;
      logic rvalid;
      logic err;
      logic depth;
      logic [31:0] prdata;
      logic tload;
      logic [TMR_W-1:0] tlen;
   } afc_ctrl_t;

   afc_ctrl_t r;
   afc_ctrl_t next_r;

   logic [SW-1:0] pins_s;
   logic [NDEV-1:0] empty_s;
   logic [NDEV-1:0] full_s;
   logic half_s;
   logic [DW-1:0] dout_s;
   logic t_expired;
   logic comp_empty_n;
   logic comp_full_n;
   logic setup;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic cmd_clear;
   logic cmd_replay;
   logic cmd_read;
   logic cmd_write;
   logic ctrl_write;
   logic [31:0] status;

   function automatic logic afc_addr_ok(input logic [ADDR_W-1:0] a);
      return (a == OFS_CTRL) || (a == OFS_CMD) || (a == OFS_WDATA)
         || (a == OFS_RDATA) || (a == OFS_STATUS);
   endfunction

   function automatic logic [TMR_W-1:0] afc_len(input int unsigned cyc);
      return TMR_W'(cyc);
   endfunction

   afc_sync #(
      .W(SW)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({empty_ind_n, full_ind_n, half_ind_n, dout}),
      .dout(pins_s)
   );

   afc_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(r.tload),
      .len(r.tlen),
      .expired(t_expired)
   );

   assign empty_s = pins_s[SW-1 -: NDEV];
   assign full_s = pins_s[SW-1-NDEV -: NDEV];
   assign half_s = pins_s[DW];
   assign dout_s = pins_s[DW-1:0];

   // composite flag asserts only while every device asserts it
   assign comp_empty_n = |empty_s; // RULE4
   assign comp_full_n = |full_s; // RULE4

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_acc = access && pwrite && afc_addr_ok(paddr);
   assign rd_acc = access && !pwrite && afc_addr_ok(paddr);
   assign cmd_clear = wr_acc && (paddr == OFS_CMD) && pwdata[CMD_CLEAR_BIT];
   assign cmd_replay = wr_acc && (paddr == OFS_CMD) && pwdata[CMD_REPLAY_BIT];
   assign cmd_read = wr_acc && (paddr == OFS_CMD) && pwdata[CMD_READ_BIT];
   assign cmd_write = wr_acc && (paddr == OFS_WDATA);
   assign ctrl_write = wr_acc && (paddr == OFS_CTRL);

   always_comb begin
      status = '0;
      status[ST_BUSY_BIT] = (r.st != AFC_IDLE);
      status[ST_EMPTY_BIT] = !comp_empty_n;
      status[ST_FULL_BIT] = !comp_full_n;
      // the shared pin is a cascade output in a depth chain
      status[ST_HALF_BIT] = !r.depth && !half_s; // RULE5 RULE6
      status[ST_RVALID_BIT] = r.rvalid;
      status[ST_ERR_BIT] = r.err;
   end

   always_comb begin
      next_r = r;
      next_r.tload = 1'b0;

      // read data is captured during the setup cycle
      if (setup) begin
         next_r.prdata = '0;
         case (paddr)
            OFS_CTRL: begin
               next_r.prdata[CTRL_DEPTH_BIT] = r.depth;
            end
            OFS_RDATA: begin
               next_r.prdata[DW-1:0] = r.rdata;
            end
            OFS_STATUS: begin
               next_r.prdata = status;
            end
            default: begin
               next_r.prdata = '0;
            end
         endcase
      end

      // clears by software; the state machine below may set again
      if (rd_acc && (paddr == OFS_RDATA)) begin
         next_r.rvalid = 1'b0;
      end
      if (wr_acc && (paddr == OFS_STATUS) && pwdata[ST_ERR_BIT]) begin
         next_r.err = 1'b0;
      end

      case (r.st)
         AFC_IDLE: begin
            if (ctrl_write) begin
               next_r.depth = pwdata[CTRL_DEPTH_BIT];
            end
            if (cmd_clear) begin
               // strobes stay high around the clear edges
               next_r.clr_n = 1'b0; // RULE11 RULE14
               next_r.st = AFC_CLEAR;
               next_r.tload = 1'b1;
               next_r.tlen = afc_len(CLEAR_LOW_CYC);
            end else if (cmd_replay) begin
               if (r.depth) begin
                  next_r.err = 1'b1; // RULE5
               end else begin
                  next_r.rt_n = 1'b0; // RULE12
                  next_r.st = AFC_REPLAY;
                  next_r.tload = 1'b1;
                  next_r.tlen = afc_len(STROBE_LOW_CYC);
               end
            end else if (cmd_read) begin
               next_r.op = AFC_OP_RD;
               next_r.st = AFC_WAIT;
            end else if (cmd_write) begin
               next_r.din = pwdata[DW-1:0];
               next_r.op = AFC_OP_WR;
               next_r.st = AFC_WAIT;
            end
         end
         AFC_WAIT: begin
            if (r.op == AFC_OP_WR && comp_full_n) begin
               next_r.wr_n = 1'b0; // RULE10 RULE15
               next_r.st = AFC_LOW;
               next_r.tload = 1'b1;
               next_r.tlen = afc_len(STROBE_LOW_CYC);
            end else if (r.op == AFC_OP_RD && comp_empty_n) begin
               next_r.rd_n = 1'b0; // RULE15
               next_r.st = AFC_LOW;
               next_r.tload = 1'b1;
               next_r.tlen = afc_len(STROBE_LOW_CYC);
            end
         end
         AFC_LOW: begin
            if (t_expired) begin
               next_r.wr_n = 1'b1;
               next_r.rd_n = 1'b1;
               next_r.st = AFC_REC;
               next_r.tload = 1'b1;
               next_r.tlen = afc_len(RECOVER_CYC);
            end
         end
         AFC_CLEAR: begin
            if (t_expired) begin
               next_r.clr_n = 1'b1;
               next_r.st = AFC_REC;
               next_r.tload = 1'b1;
               next_r.tlen = afc_len(RECOVER_CYC);
            end
         end
         AFC_REPLAY: begin
            if (t_expired) begin
               next_r.rt_n = 1'b1;
               next_r.st = AFC_REC;
               next_r.tload = 1'b1;
               next_r.tlen = afc_len(RECOVER_CYC);
            end
         end
         AFC_REC: begin
            // the synchroniser lags the pin, so it still holds the word seen under the strobe
            if (r.op == AFC_OP_RD) begin
               next_r.rdata = dout_s;
               next_r.rvalid = 1'b1;
            end
            next_r.op = AFC_OP_NONE;
            // recovery also lets the flag synchronisers settle
            if (t_expired) begin
               next_r.st = AFC_IDLE;
            end
         end
         default: begin
            next_r.st = AFC_IDLE;
         end
      endcase

      // a command while busy is dropped and flagged
      if (r.st != AFC_IDLE && (cmd_clear || cmd_replay || cmd_read || cmd_write
          || ctrl_write)) begin
         next_r.err = 1'b1;
      end

      // device zero heads the chain; in single mode the pin is replay
      for (int i = 0; i < NDEV; i++) begin
         if (next_r.depth) begin
            next_r.head_n[i] = (i != 0); // RULE2
         end else begin
            next_r.head_n[i] = next_r.rt_n; // RULE6
         end
      end
   end

   // host reset starts with a device clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.st <= AFC_CLEAR;
         r.op <= AFC_OP_NONE;
         r.wr_n <= 1'b1;
         r.rd_n <= 1'b1;
         r.clr_n <= 1'b0;
         r.rt_n <= 1'b1;
         r.head_n <= '1;
         r.din <= '0;
         r.rdata <= '0;
         r.rvalid <= 1'b0;
         r.err <= 1'b0;
         r.depth <= CTRL_DEPTH_RST;
         r.prdata <= '0;
         r.tload <= 1'b1;
         r.tlen <= afc_len(CLEAR_LOW_CYC);
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign pready = 1'b1;
   assign pslverr = access && !afc_addr_ok(paddr);
   assign wr_n = r.wr_n;
   assign rd_n = r.rd_n;
   assign din = r.din;
   assign clear_n = r.clr_n;
   assign chain_head_or_replay_n = r.head_n;
endmodule

/* File: sim/afc_monitor.sv */
`timescale 1ns/100ps
module afc_monitor
   import afc_pkg::*;
#(
   parameter int unsigned NDEV = 1,
   parameter int unsigned DW = 9
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [DW-1:0] din,
   input wire logic [DW-1:0] dout,
   input wire logic clear_n,
   input wire logic [NDEV-1:0] chain_head_or_replay_n,
   input wire logic [NDEV-1:0] empty_ind_n,
   input wire logic [NDEV-1:0] full_ind_n,
   input wire logic half_ind_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_wr_not_full: assert property ($fell(wr_n) |-> |full_ind_n)
      else $error("write strobe while composite full");
   a_rd_not_empty: assert property ($fell(rd_n) |-> |empty_ind_n)
      else $error("read strobe while composite empty");
   a_strobes_apart: assert property (wr_n || rd_n)
      else $error("both strobes low");
   a_wr_width: assert property ($fell(wr_n) |-> !wr_n[*4] ##1 wr_n)
      else $error("write strobe width wrong");
   a_rd_width: assert property ($fell(rd_n) |-> !rd_n[*4] ##1 rd_n)
      else $error("read strobe width wrong");
   a_din_held: assert property (!wr_n |-> $stable(din))
      else $error("data moved under write strobe");
   a_clear_quiet: assert property (!clear_n |-> wr_n && rd_n)
      else $error("strobe during clear");
   a_reset_clear: assert property ($rose(presetn) |-> !clear_n)
      else $error("no clear after reset");
   a_head_rest: assert property (chain_head_or_replay_n[0] |-> &chain_head_or_replay_n)
      else $error("head select on a later device");
   a_replay_quiet: assert property (!(|chain_head_or_replay_n) |-> wr_n && rd_n)
      else $error("strobe during replay");
   cover property ($fell(wr_n));
   cover property ($fell(rd_n));
   cover property ($fell(chain_head_or_replay_n[0]) && chain_head_or_replay_n[NDEV-1]);
endmodule
bind afc_ctrl afc_monitor #(.NDEV(NDEV), .DW(DW)) mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_n(wr_n), .rd_n(rd_n),
   .din(din), .dout(dout), .clear_n(clear_n), .chain_head_or_replay_n(chain_head_or_replay_n),
   .empty_ind_n(empty_ind_n), .full_ind_n(full_ind_n), .half_ind_n(half_ind_n));

/* File: sim/afc_fifo_model.sv */
`timescale 1ns/100ps
module afc_fifo_model #(
   parameter int DEPTH = 8
) (
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic [8:0] d,
   output logic [8:0] q,
   input wire logic clear_n,
   input wire logic head_or_replay_n,
   input wire logic cascade_in_n,
   output logic empty_ind_n,
   output logic full_ind_n,
   output logic half_ind_n
);
   int wr_t = 0;
   int rd_t = 0;
   logic wr_q = 1'b1;
   logic rd_q = 1'b1;
   logic wr_ok = 1'b0;
   logic rd_ok = 1'b0;
   logic [8:0] last = 9'h000;
   logic [8:0] mem [DEPTH];
   // released outputs show the inverse of the last word, never a held value
   assign q = (!rd_n && rd_ok) ? last : ~last;
   assign empty_ind_n = wr_t != rd_t;
   assign full_ind_n = (wr_t - rd_t) != DEPTH;
   assign half_ind_n = cascade_in_n || (wr_t - rd_t) <= DEPTH / 2;
   always @(wr_n or rd_n or clear_n or head_or_replay_n or cascade_in_n) begin
      if (!clear_n) begin
         wr_t = 0;
         rd_t = 0;
         wr_ok = 1'b0;
         rd_ok = 1'b0;
      end else if (!head_or_replay_n && !cascade_in_n) begin
         rd_t = 0;
      end else begin
         if (!wr_n && wr_q) wr_ok = (wr_t - rd_t) < DEPTH;
         if (wr_n && !wr_q && wr_ok) begin
            mem[wr_t % DEPTH] = d;
            wr_t++;
            wr_ok = 1'b0;
            // a read held low on an empty buffer takes the new word at once
            if (!rd_n && !rd_ok) begin
               rd_ok = 1'b1;
               last = mem[rd_t % DEPTH];
            end
         end
         if (!rd_n && rd_q) begin
            rd_ok = wr_t != rd_t;
            if (rd_ok) last = mem[rd_t % DEPTH];
         end
         if (rd_n && !rd_q && rd_ok) begin
            rd_t++;
            rd_ok = 1'b0;
            // a write held low on a full buffer stores on its own rise
            if (!wr_n && !wr_ok) begin
               wr_ok = 1'b1;
            end
         end
      end
      wr_q = wr_n;
      rd_q = rd_n;
   end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import afc_pkg::*;
   localparam int DEPTH = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic depth = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, wr_n, rd_n, clear_n, half_ind_n, er;
   logic [8:0] din, dout;
   logic [1:0] head_n, empty_ind_n, full_ind_n;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   integer seed = 32'h08bd71ca;
   logic [8:0] q[$];
   logic [8:0] hist[$];
   always #50 pclk = ~pclk;
   afc_ctrl #(.NDEV(2), .DW(9)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wr_n(wr_n), .rd_n(rd_n), .din(din), .dout(dout),
      .clear_n(clear_n), .chain_head_or_replay_n(head_n), .empty_ind_n(empty_ind_n),
      .full_ind_n(full_ind_n), .half_ind_n(half_ind_n));
   // both devices share strobes, data and clear; empty and full come from both, half from device zero
   afc_fifo_model #(.DEPTH(DEPTH)) dev0 (.wr_n(wr_n), .rd_n(rd_n), .d(din), .q(dout),
      .clear_n(clear_n), .head_or_replay_n(head_n[0]), .cascade_in_n(depth),
      .empty_ind_n(empty_ind_n[0]), .full_ind_n(full_ind_n[0]), .half_ind_n(half_ind_n));
   afc_fifo_model #(.DEPTH(DEPTH)) dev1 (.wr_n(wr_n), .rd_n(rd_n), .d(din), .q(),
      .clear_n(clear_n), .head_or_replay_n(head_n[1]), .cascade_in_n(depth),
      .empty_ind_n(empty_ind_n[1]), .full_ind_n(full_ind_n[1]), .half_ind_n());
   function automatic logic [31:0] exp_st(input int n);
      return {28'h0, n > DEPTH / 2 && !depth, n == DEPTH, n == 0, 1'b0};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle();
      rd = 32'h1;
      while (rd[ST_BUSY_BIT] !== 1'b0) begin
         apb(1'b0, OFS_STATUS, 32'h0);
      end
   endtask
   task automatic stat(input int n);
      apb(1'b0, OFS_STATUS, 32'h0);
      check({28'h0, rd[3:1], 1'b0}, exp_st(n));
   endtask
   task automatic push(input logic [8:0] v);
      apb(1'b1, OFS_WDATA, {23'h0, v});
      idle();
      q.push_back(v);
      hist.push_back(v);
   endtask
   task automatic pop(input logic [8:0] exp);
      apb(1'b1, OFS_CMD, 32'h4);
      idle();
      check({31'h0, rd[ST_RVALID_BIT]}, 32'h1);
      apb(1'b0, OFS_RDATA, 32'h0);
      check(rd, {23'h0, exp});
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      idle();
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd, 32'h0);
      stat(0);
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, er}, 32'h1);
      push(9'h1ff);
      push(9'h000);
      apb(1'b1, OFS_CMD, 32'h1);
      idle();
      stat(0);
      q.delete();
      hist.delete();
      for (int i = 0; i < 5; i++) push(9'($random(seed)));
      stat(5);
      pop(q.pop_front());
      pop(q.pop_front());
      apb(1'b1, OFS_CMD, 32'h2);
      idle();
      q = hist;
      stat(5);
      pop(q.pop_front());
      for (int i = 0; i < 4; i++) push(9'($random(seed)));
      stat(DEPTH);
      while (q.size() > 0) pop(q.pop_front());
      stat(0);
      apb(1'b1, OFS_CMD, 32'h4);
      repeat (40) @(posedge pclk);
      check({31'h0, rd_n}, 32'h1);
      apb(1'b1, OFS_CMD, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check({30'h0, rd[ST_ERR_BIT], rd[ST_BUSY_BIT]}, 32'h3);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      idle();
      stat(0);
      apb(1'b1, OFS_CTRL, 32'h1);
      depth <= 1'b1;
      @(posedge pclk);
      check({30'h0, head_n}, 32'h2);
      apb(1'b1, OFS_CMD, 32'h2);
      apb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd[ST_ERR_BIT]}, 32'h1);
      apb(1'b1, OFS_STATUS, 32'h20);
      apb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd[ST_ERR_BIT]}, 32'h0);
      for (int i = 0; i < 5; i++) push(9'($random(seed)));
      stat(5);
      while (q.size() > 0) pop(q.pop_front());
      give_verdict();
   end
endmodule
